// File: src/vag_consts.svh
// Constants of the video decoder gain-control register bank
`ifndef VAG_CONSTS_SVH
`define VAG_CONSTS_SVH

// Subaddresses
`define VAG_OFS_OP_CTRL 8'h03
`define VAG_OFS_FIELD_FLAG 8'h69
`define VAG_OFS_CHROMA_CTRL 8'h6A
`define VAG_OFS_BACKEND_CTRL 8'h6C
`define VAG_OFS_DEC_SPEED 8'h6F
`define VAG_OFS_FW_VERSION 8'h70
`define VAG_OFS_VERT_FLAG 8'h75
`define VAG_OFS_INC_SPEED 8'h78
`define VAG_OFS_INC_DELAY 8'h79
`define VAG_OFS_DEC_DELAY 8'h9E
`define VAG_OFS_RANGE 8'h9F

// Reset values
`define VAG_RST_OP_CTRL 8'h00
`define VAG_RST_FIELD_FLAG 8'h00
`define VAG_RST_CHROMA_CTRL 8'h0A
`define VAG_RST_BACKEND_CTRL 8'h08
`define VAG_RST_DEC_SPEED 8'h04
`define VAG_RST_VERT_FLAG 8'h00
`define VAG_RST_INC_SPEED 8'h05
`define VAG_RST_INC_DELAY 8'h1E
`define VAG_RST_DEC_DELAY 8'h00
`define VAG_RST_RANGE 8'h06

// Field positions
`define VAG_SPEED_MSB 2
`define VAG_RANGE_MSB 2
`define VAG_THRESH_MSB 3
`define VAG_CHROMA_EN_BIT 4
`define VAG_BE_SYNC_BIT 0
`define VAG_BE_BURST_BIT 1
`define VAG_BE_PEAK_BIT 2
`define VAG_BE_ONE_BIT 3

// Range encodings
`define VAG_RANGE_125 3'h5
`define VAG_RANGE_150 3'h6
`define VAG_RANGE_175 3'h7

`endif

// File: src/vag_pkg.sv
// Types of the video decoder gain-control register bank
package vag_pkg;

  // Reference the front-end gain loop is tracking
  typedef enum logic [1:0] {
    VAG_REF_SYNC,
    VAG_REF_BURST,
    VAG_REF_PEAK,
    VAG_REF_OTHER
  } vag_ref_e;

  // Upper bound of the gain window, lower bound always 1.0
  typedef enum logic [1:0] {
    VAG_MAX_1P25,
    VAG_MAX_1P50,
    VAG_MAX_1P75
  } vag_max_e;

  // Host register access from the serial-interface front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vag_req_s;

  // Settings handed to the gain loops and the 656 formatter
  typedef struct packed {
    logic [2:0] inc_speed;
    logic [7:0] inc_delay;
    logic [2:0] dec_speed;
    logic [7:0] dec_delay;
    vag_max_e max_gain;
    logic chroma_gain_active;
    logic backend_gain_off;
    logic [7:0] field_flag_ctrl;
    logic [7:0] vert_flag_ctrl;
    logic [7:0] op_ctrl;
  } vag_cfg_s;

endpackage

// File: src/vag_regbank.sv
// Gain-control register bank with derived loop settings
`timescale 1ns/1ps
`include "vag_consts.svh"

module vag_regbank #(
  parameter logic [7:0] FW_VERSION = 8'h5A // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Register access
  input wire vag_pkg::vag_req_s req,
  output vag_pkg::vag_req_s req_unused_dummy_n,
  output logic [7:0] rdata,
  output logic rvalid,
  // Video-path status
  input wire vag_pkg::vag_ref_e fe_ref,
  input wire logic [3:0] chroma_amp,
  // Settings out
  output vag_pkg::vag_cfg_s cfg
);

  logic [7:0] op_ctrl_reg;
  logic [7:0] field_flag_reg;
  logic [7:0] vert_flag_reg;
  logic [7:0] chroma_ctrl_reg;
  logic [7:0] backend_ctrl_reg;
  logic [7:0] dec_speed_reg;
  logic [7:0] inc_speed_reg;
  logic [7:0] inc_delay_reg;
  logic [7:0] dec_delay_reg;
  logic [7:0] range_reg;
  logic [7:0] rdata_next;
  vag_pkg::vag_cfg_s cfg_next;

  // Decode the range field; reserved codes fall back to the 1.5 window
  function automatic vag_pkg::vag_max_e range_decode(input logic [2:0] code);
    case (code)
      `VAG_RANGE_125: range_decode = vag_pkg::VAG_MAX_1P25;
      `VAG_RANGE_150: range_decode = vag_pkg::VAG_MAX_1P50;
      `VAG_RANGE_175: range_decode = vag_pkg::VAG_MAX_1P75;
      default: range_decode = vag_pkg::VAG_MAX_1P50;
    endcase
  endfunction

  // Write strobe for one subaddress
  function automatic logic wr_hit(input vag_pkg::vag_req_s r, input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // Spare output kept quiet; nothing echoes the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_unused_dummy_n <= '0;
    end else if (ce) begin
      req_unused_dummy_n <= '0;
    end
  end

  // Writable registers; firmware version has no storage so writes vanish
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_ctrl_reg <= `VAG_RST_OP_CTRL;
      field_flag_reg <= `VAG_RST_FIELD_FLAG;
      vert_flag_reg <= `VAG_RST_VERT_FLAG;
      chroma_ctrl_reg <= `VAG_RST_CHROMA_CTRL;
      backend_ctrl_reg <= `VAG_RST_BACKEND_CTRL;
      dec_speed_reg <= `VAG_RST_DEC_SPEED;
      inc_speed_reg <= `VAG_RST_INC_SPEED;
      inc_delay_reg <= `VAG_RST_INC_DELAY;
      dec_delay_reg <= `VAG_RST_DEC_DELAY;
      range_reg <= `VAG_RST_RANGE;
    end else if (ce) begin
      if (wr_hit(req, `VAG_OFS_OP_CTRL)) op_ctrl_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_FIELD_FLAG)) field_flag_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_VERT_FLAG)) vert_flag_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_CHROMA_CTRL)) chroma_ctrl_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_BACKEND_CTRL)) backend_ctrl_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_DEC_SPEED)) dec_speed_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_INC_SPEED)) inc_speed_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_INC_DELAY)) inc_delay_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_DEC_DELAY)) dec_delay_reg <= req.wdata;
      if (wr_hit(req, `VAG_OFS_RANGE)) range_reg <= req.wdata;
    end
  end

  // Read mux; unmapped subaddresses read as zero
  always_comb begin
    case (req.addr)
      `VAG_OFS_OP_CTRL: rdata_next = op_ctrl_reg;
      `VAG_OFS_FIELD_FLAG: rdata_next = field_flag_reg;
      `VAG_OFS_VERT_FLAG: rdata_next = vert_flag_reg;
      `VAG_OFS_CHROMA_CTRL: rdata_next = chroma_ctrl_reg;
      `VAG_OFS_BACKEND_CTRL: rdata_next = backend_ctrl_reg;
      `VAG_OFS_DEC_SPEED: rdata_next = dec_speed_reg;
      `VAG_OFS_FW_VERSION: rdata_next = FW_VERSION;
      `VAG_OFS_INC_SPEED: rdata_next = inc_speed_reg;
      `VAG_OFS_INC_DELAY: rdata_next = inc_delay_reg;
      `VAG_OFS_DEC_DELAY: rdata_next = dec_delay_reg;
      `VAG_OFS_RANGE: rdata_next = range_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rdata_next;
      end
    end
  end

  // Derived settings, computed from the registers and live video status
  always_comb begin
    cfg_next = '0;
    cfg_next.inc_speed = inc_speed_reg[`VAG_SPEED_MSB:0];
    cfg_next.inc_delay = inc_delay_reg;
    // Decrement speed only steers peak-tracking loops
    cfg_next.dec_speed = (fe_ref == vag_pkg::VAG_REF_PEAK) ? dec_speed_reg[`VAG_SPEED_MSB:0] : 3'h0;
    cfg_next.dec_delay = dec_delay_reg;
    cfg_next.max_gain = range_decode(range_reg[`VAG_RANGE_MSB:0]);
    // Without the enable bit the chroma loop runs ungated
    cfg_next.chroma_gain_active = !chroma_ctrl_reg[`VAG_CHROMA_EN_BIT] ||
      (chroma_amp >= chroma_ctrl_reg[`VAG_THRESH_MSB:0]);
    case (fe_ref)
      vag_pkg::VAG_REF_SYNC: cfg_next.backend_gain_off = backend_ctrl_reg[`VAG_BE_SYNC_BIT];
      vag_pkg::VAG_REF_BURST: cfg_next.backend_gain_off = backend_ctrl_reg[`VAG_BE_BURST_BIT];
      vag_pkg::VAG_REF_PEAK: cfg_next.backend_gain_off = backend_ctrl_reg[`VAG_BE_PEAK_BIT];
      default: cfg_next.backend_gain_off = 1'b0;
    endcase
    cfg_next.field_flag_ctrl = field_flag_reg;
    cfg_next.vert_flag_ctrl = vert_flag_reg;
    cfg_next.op_ctrl = op_ctrl_reg;
  end

  // Registered settings so every output leaves a flip-flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
      cfg.max_gain <= vag_pkg::VAG_MAX_1P50;
    end else if (ce) begin
      cfg <= cfg_next;
    end
  end

  // Checks
  a_inc_speed_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_INC_SPEED) ##1 ce |=> cfg.inc_speed == $past(req.wdata[2:0], 2))
    else $error("increment speed not passed on");
  a_dec_speed_ref: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref != vag_pkg::VAG_REF_PEAK |=> cfg.dec_speed == 3'h0)
    else $error("decrement speed active off peak reference");
  a_range_decode: assert property (@(posedge core_clk) disable iff (rst)
    ce && range_reg[2:0] == 3'h7 |=> cfg.max_gain == vag_pkg::VAG_MAX_1P75)
    else $error("range 111 not decoded to 1.75");
  a_reset_defaults: assert property (@(posedge core_clk)
    $fell(rst) |-> range_reg == 8'h06 && inc_delay_reg == 8'h1E && backend_ctrl_reg == 8'h08)
    else $error("register default missing after reset");
  a_chroma_below: assert property (@(posedge core_clk) disable iff (rst)
    ce && chroma_ctrl_reg[4] && chroma_amp < chroma_ctrl_reg[3:0] |=> !cfg.chroma_gain_active)
    else $error("chroma gain active below threshold");
  a_chroma_ungated: assert property (@(posedge core_clk) disable iff (rst)
    ce && !chroma_ctrl_reg[4] |=> cfg.chroma_gain_active)
    else $error("chroma gating without enable bit");
  a_backend_sync: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref == vag_pkg::VAG_REF_SYNC |=> cfg.backend_gain_off == $past(backend_ctrl_reg[0]))
    else $error("sync reference back-end control wrong");
  a_backend_burst: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref == vag_pkg::VAG_REF_BURST |=> cfg.backend_gain_off == $past(backend_ctrl_reg[1]))
    else $error("burst reference back-end control wrong");
  a_backend_peak: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref == vag_pkg::VAG_REF_PEAK |=> cfg.backend_gain_off == $past(backend_ctrl_reg[2]))
    else $error("peak reference back-end control wrong");
  a_flag_ctrl_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_VERT_FLAG) ##1 ce |=> cfg.vert_flag_ctrl == $past(req.wdata, 2))
    else $error("vertical flag control not passed on");
  a_fw_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == 8'h70 |=> rvalid && rdata == FW_VERSION)
    else $error("firmware version read wrong");

  // Each write lands in its own register at the taking edge
  a_op_ctrl_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_OP_CTRL) |=> op_ctrl_reg == $past(req.wdata))
    else $error("operation control write lost");
  a_field_flag_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_FIELD_FLAG) |=> field_flag_reg == $past(req.wdata))
    else $error("field flag control write lost");
  a_chroma_ctrl_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_CHROMA_CTRL) |=> chroma_ctrl_reg == $past(req.wdata))
    else $error("chroma control write lost");
  a_backend_ctrl_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_BACKEND_CTRL) |=> backend_ctrl_reg == $past(req.wdata))
    else $error("back-end control write lost");
  a_dec_speed_reg: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_DEC_SPEED) |=> dec_speed_reg == $past(req.wdata))
    else $error("decrement speed write lost");
  a_inc_speed_reg: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_INC_SPEED) |=> inc_speed_reg == $past(req.wdata))
    else $error("increment speed write lost");
  a_inc_delay_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_INC_DELAY) |=> inc_delay_reg == $past(req.wdata))
    else $error("increment delay write lost");
  a_dec_delay_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_DEC_DELAY) |=> dec_delay_reg == $past(req.wdata))
    else $error("decrement delay write lost");
  a_range_wr: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_RANGE) |=> range_reg == $past(req.wdata))
    else $error("range control write lost");

  // Without a matching write a register holds; catches decode aliasing
  a_range_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !wr_hit(req, `VAG_OFS_RANGE) |=> $stable(range_reg))
    else $error("range control changed without a write");
  a_backend_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !wr_hit(req, `VAG_OFS_BACKEND_CTRL) |=> $stable(backend_ctrl_reg))
    else $error("back-end control changed without a write");
  a_chroma_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !wr_hit(req, `VAG_OFS_CHROMA_CTRL) |=> $stable(chroma_ctrl_reg))
    else $error("chroma control changed without a write");
  a_dec_speed_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !wr_hit(req, `VAG_OFS_DEC_SPEED) |=> $stable(dec_speed_reg))
    else $error("decrement speed changed without a write");
  a_inc_delay_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !wr_hit(req, `VAG_OFS_INC_DELAY) |=> $stable(inc_delay_reg))
    else $error("increment delay changed without a write");

  // Version subaddress has no storage, so a write there touches nothing
  a_fw_wr_ignored: assert property (@(posedge core_clk) disable iff (rst)
    ce && wr_hit(req, `VAG_OFS_FW_VERSION) |=> $stable(inc_delay_reg) && $stable(range_reg) && $stable(backend_ctrl_reg))
    else $error("version write disturbed a register");

  // Enable low freezes registers, read port and settings alike
  a_freeze_regs: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(inc_speed_reg) && $stable(inc_delay_reg) && $stable(range_reg))
    else $error("register moved while enable low");
  a_freeze_cfg: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(cfg))
    else $error("settings moved while enable low");
  a_freeze_read: assert property (@(posedge core_clk) disable iff (rst)
    !ce |=> $stable(rdata) && $stable(rvalid))
    else $error("read port moved while enable low");

  // Read port: one-cycle answer, data held between reads
  a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (rst)
    ce && !req.rd |=> !rvalid)
    else $error("read answer without a read");
  a_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_range_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == `VAG_OFS_RANGE |=> rvalid && rdata == $past(range_reg))
    else $error("range control read wrong");
  a_backend_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == `VAG_OFS_BACKEND_CTRL |=> rvalid && rdata == $past(backend_ctrl_reg))
    else $error("back-end control read wrong");
  a_chroma_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == `VAG_OFS_CHROMA_CTRL |=> rvalid && rdata == $past(chroma_ctrl_reg))
    else $error("chroma control read wrong");
  a_inc_delay_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == `VAG_OFS_INC_DELAY |=> rvalid && rdata == $past(inc_delay_reg))
    else $error("increment delay read wrong");
  a_dec_delay_read: assert property (@(posedge core_clk) disable iff (rst)
    ce && req.rd && req.addr == `VAG_OFS_DEC_DELAY |=> rvalid && rdata == $past(dec_delay_reg))
    else $error("decrement delay read wrong");

  // Remaining legal range codes
  a_range_low: assert property (@(posedge core_clk) disable iff (rst)
    ce && range_reg[`VAG_RANGE_MSB:0] == `VAG_RANGE_125 |=> cfg.max_gain == vag_pkg::VAG_MAX_1P25)
    else $error("range 101 not decoded to 1.25");
  a_range_mid: assert property (@(posedge core_clk) disable iff (rst)
    ce && range_reg[`VAG_RANGE_MSB:0] == `VAG_RANGE_150 |=> cfg.max_gain == vag_pkg::VAG_MAX_1P50)
    else $error("range 110 not decoded to 1.5");

  // Settings outputs follow their registers one edge later
  a_chroma_above: assert property (@(posedge core_clk) disable iff (rst)
    ce && chroma_ctrl_reg[4] && chroma_amp >= chroma_ctrl_reg[3:0] |=> cfg.chroma_gain_active)
    else $error("chroma gain idle at or above threshold");
  a_backend_other: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref == vag_pkg::VAG_REF_OTHER |=> !cfg.backend_gain_off)
    else $error("back-end gain off under an unlisted reference");
  a_dec_speed_peak: assert property (@(posedge core_clk) disable iff (rst)
    ce && fe_ref == vag_pkg::VAG_REF_PEAK |=> cfg.dec_speed == $past(dec_speed_reg[`VAG_SPEED_MSB:0]))
    else $error("decrement speed lost under peak reference");
  a_inc_delay_out: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> cfg.inc_delay == $past(inc_delay_reg))
    else $error("increment delay not passed on");
  a_dec_delay_out: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> cfg.dec_delay == $past(dec_delay_reg))
    else $error("decrement delay not passed on");
  a_field_flag_out: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> cfg.field_flag_ctrl == $past(field_flag_reg))
    else $error("field flag control not passed on");
  a_op_ctrl_out: assert property (@(posedge core_clk) disable iff (rst)
    ce |=> cfg.op_ctrl == $past(op_ctrl_reg))
    else $error("operation control not passed on");

  // Reset leaves read port, settings and the other registers at idle values
  a_reset_read: assert property (@(posedge core_clk)
    $fell(rst) |-> !rvalid && rdata == 8'h00 && cfg.max_gain == vag_pkg::VAG_MAX_1P50)
    else $error("read port or settings not idle after reset");
  a_reset_other: assert property (@(posedge core_clk)
    $fell(rst) |-> chroma_ctrl_reg == `VAG_RST_CHROMA_CTRL && dec_speed_reg == `VAG_RST_DEC_SPEED &&
      inc_speed_reg == `VAG_RST_INC_SPEED && dec_delay_reg == `VAG_RST_DEC_DELAY)
    else $error("gain register default missing after reset");

endmodule

// File: tb/tb_top.sv
// Self-checking bench for the gain-control register bank
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  vag_pkg::vag_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  vag_pkg::vag_ref_e fe_ref = vag_pkg::VAG_REF_SYNC;
  logic [3:0] chroma_amp = 4'h0;
  vag_pkg::vag_cfg_s cfg;
  vag_pkg::vag_req_s spare;
  localparam logic [7:0] FW_CODE = 8'hC3; // Arbitrary value, replaces the default
  logic [7:0] exp_q[$];
  logic [7:0] wv;
  int n_errors = 0;
  int cmp_count = 0;
  // Writable registers and their defaults, range register last
  logic [7:0] ofs[10] = '{8'h03, 8'h69, 8'h6A, 8'h6C, 8'h6F, 8'h75, 8'h78, 8'h79, 8'h9E, 8'h9F};
  logic [7:0] dflt[10] = '{8'h00, 8'h00, 8'h0A, 8'h08, 8'h04, 8'h00, 8'h05, 8'h1E, 8'h00, 8'h06};

  always #10 core_clk = ~core_clk;

  vag_regbank #(.FW_VERSION(FW_CODE)) u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .req(req),
    .req_unused_dummy_n(spare),
    .rdata(rdata), .rvalid(rvalid), .fe_ref(fe_ref), .chroma_amp(chroma_amp), .cfg(cfg));
  vag_host u_host (.core_clk(core_clk), .req(req));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Expectation noted before the read goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.access(1'b0, a, 8'h00);
  endtask

  // Let a write reach the settings outputs
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // Each read answer is matched to the oldest expectation, mid-cycle where it has settled
  always @(negedge core_clk) begin
    if (rvalid === 1'b1 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
  end

  // Whole run is a few hundred cycles; this only catches a hang
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(73));
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 10; i++) rd(ofs[i], dflt[i]);
    rd(8'h70, FW_CODE);
    rd(8'h55, 8'h00);
    u_host.power_on();
    rd(8'h03, 8'h00);
    settle();
    chk({5'h0, cfg.inc_speed}, 8'h05);
    chk(cfg.inc_delay, 8'h1E);
    chk({6'h0, cfg.max_gain}, 8'h01);
    // Random readback of every writable register but the range register
    for (int i = 0; i < 9; i++) begin
      wv = 8'($urandom());
      u_host.access(1'b1, ofs[i], wv);
      rd(ofs[i], (ofs[i] == 8'h6C) ? (wv | 8'h08) : wv);
      // The write has reached the settings outputs by now
      case (ofs[i])
        8'h03: chk(cfg.op_ctrl, wv);
        8'h69: chk(cfg.field_flag_ctrl, wv);
        8'h75: chk(cfg.vert_flag_ctrl, wv);
        8'h78: chk({5'h0, cfg.inc_speed}, {5'h0, wv[2:0]});
        8'h79: chk(cfg.inc_delay, wv);
        8'h9E: chk(cfg.dec_delay, wv);
        default: ;
      endcase
    end
    u_host.access(1'b1, 8'h70, 8'hA5);
    rd(8'h70, FW_CODE);
    // All three legal range codes
    for (int c = 5; c < 8; c++) begin
      u_host.access(1'b1, 8'h9F, 8'(c));
      settle();
      chk({6'h0, cfg.max_gain}, 8'(c - 5));
    end
    // Threshold gating, enabled and bypassed
    for (int k = 0; k < 12; k++) begin
      wv = 8'($urandom()) & 8'h1F;
      chroma_amp = (k < 4) ? wv[3:0] : 4'($urandom());
      u_host.access(1'b1, 8'h6A, wv);
      settle();
      chk({7'h0, cfg.chroma_gain_active}, {7'h0, !wv[4] || chroma_amp >= wv[3:0]});
    end
    // Every reference against every disable mask
    u_host.access(1'b1, 8'h6F, 8'h03);
    for (int r = 0; r < 4; r++) begin
      fe_ref = vag_pkg::vag_ref_e'(r);
      for (int m = 0; m < 8; m++) begin
        u_host.access(1'b1, 8'h6C, 8'(m));
        settle();
        chk({7'h0, cfg.backend_gain_off}, {7'h0, r < 3 && m[r]});
        chk({5'h0, cfg.dec_speed}, (r == 2) ? 8'h03 : 8'h00);
      end
    end
    // Reset in mid-run brings defaults back
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 10; i++) rd(ofs[i], dflt[i]);
    settle();
    // Enable low: the write is dropped and the settings hold
    ce = 1'b0;
    u_host.access(1'b1, 8'h79, 8'h3C);
    chk(cfg.inc_delay, 8'h1E);
    ce = 1'b1;
    rd(8'h79, 8'h1E);
    u_host.access(1'b1, 8'h79, 8'h3C);
    rd(8'h79, 8'h3C);
    settle();
    chk({7'h0, spare !== '0}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule

// File: tb/vag_host.sv
// Host controller model issuing register accesses to the gain-control bank
`timescale 1ns/1ps
module vag_host (
  // Clock
  input wire logic core_clk,
  // Register access
  output vag_pkg::vag_req_s req
);
  initial req = '0;

  // One access per call, none for writes to E8-EA: launched after an edge, held over the taking edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dv;
    dv = d;
    if (w && a >= 8'hE8 && a <= 8'hEA) return;
    if (w && a == 8'h9F && d[2:0] < 3'h5) dv = {d[7:3], 3'h6};
    if (w && a == 8'h6C) dv = d | 8'h08;
    @(posedge core_clk);
    #1;
    req = '{wr: w, rd: !w, addr: a, wdata: dv};
    @(posedge core_clk);
    #1;
    // Idle lines flip so a stale value never looks valid
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dv};
  endtask

  // Start-up writes to the operation control register
  task automatic power_on();
    access(1'b1, 8'h03, 8'h01);
    access(1'b1, 8'h03, 8'h00);
  endtask
endmodule
